// ---- verilog/p5g_pkg.sv ----
package p5g_pkg;

    // Number of configurable pins on the port
    localparam int unsigned PIN_CNT = 6;

    // Register indices (byte address is four times the index)
    localparam logic [7:0] PORT5_PIN0_CONFIG_IDX = 8'h3F;
    localparam logic [7:0] PORT5_PIN1_CONFIG_IDX = 8'h40;
    localparam logic [7:0] PORT5_PIN2_CONFIG_IDX = 8'h41;
    localparam logic [7:0] PORT5_PIN3_CONFIG_IDX = 8'h42;
    localparam logic [7:0] PORT5_PIN4_CONFIG_IDX = 8'h43;
    localparam logic [7:0] PORT5_PIN5_CONFIG_IDX = 8'h44;

    // Legacy interrupt line reached by each pin
    localparam logic [3:0] PORT5_PIN0_IRQ = 4'h3;
    localparam logic [3:0] PORT5_PIN1_IRQ = 4'h4;
    localparam logic [3:0] PORT5_PIN2_IRQ = 4'h5;
    localparam logic [3:0] PORT5_PIN3_IRQ = 4'h7;
    localparam logic [3:0] PORT5_PIN4_IRQ = 4'h9;
    localparam logic [3:0] PORT5_PIN5_IRQ = 4'hA;

    // Tables indexed by pin number
    localparam logic [PIN_CNT-1:0][7:0] PIN_REG_IDX = {
        PORT5_PIN5_CONFIG_IDX, PORT5_PIN4_CONFIG_IDX, PORT5_PIN3_CONFIG_IDX,
        PORT5_PIN2_CONFIG_IDX, PORT5_PIN1_CONFIG_IDX, PORT5_PIN0_CONFIG_IDX};
    localparam logic [PIN_CNT-1:0][3:0] PIN_IRQ_NUM = {
        PORT5_PIN5_IRQ, PORT5_PIN4_IRQ, PORT5_PIN3_IRQ,
        PORT5_PIN2_IRQ, PORT5_PIN1_IRQ, PORT5_PIN0_IRQ};

    // Field layout of a pin register, low bit first
    localparam int unsigned CFG_DIR_BIT = 0;
    localparam int unsigned CFG_INV_BIT = 1;
    localparam int unsigned CFG_SEL_LSB = 2;
    localparam int unsigned CFG_OD_BIT  = 7;

    // Values after reset and writable bits
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [7:0] CFG_WMASK = 8'h8F;

    // Function select codes
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_IRQ  = 2'h2;

    // Pin number that marks a missed decode
    localparam logic [2:0] NO_PIN = 3'h7;

    // Width of the legacy interrupt vector
    localparam int unsigned IRQ_W = 16;

    // One pin register
    typedef struct packed {
        logic       od;   // Open-drain driver when set
        logic [2:0] rsv;  // Always zero
        logic [1:0] sel;  // Function select
        logic       inv;  // Polarity inversion
        logic       dir;  // One means input
    } p5g_cfg_t;

    // Pad drive pair
    typedef struct packed {
        logic val;  // Level driven
        logic oe;   // High while driving
    } p5g_pad_t;

endpackage

// ---- verilog/p5g_cfg_reg.sv ----
`timescale 1ns/1ps
module p5g_cfg_reg (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [7:0]        wdata,
    // Stored configuration
    output p5g_pkg::p5g_cfg_t      cfg
);

    // Register image
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;

    // Reserved bits are masked off so they never store a one
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_en)
        begin
            cfg_nxt = wdata & p5g_pkg::CFG_WMASK;
        end
    end

    // Loads the idle input setting on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= p5g_pkg::CFG_RESET;
        end
        else
        begin
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg = p5g_pkg::p5g_cfg_t'(cfg_r);

endmodule

// ---- verilog/p5g_pin_cell.sv ----
`timescale 1ns/1ps
module p5g_pin_cell (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Configuration
    input  wire p5g_pkg::p5g_cfg_t cfg,
    // Board pad
    input  wire logic              pin_in,
    output logic                   pin_out,
    output logic                   pin_oe,
    // Core side
    input  wire logic              drive_val,
    input  wire logic              irq_src,
    output logic                   in_val,
    output logic                   irq_out
);

    // Synchroniser stages
    logic             meta_r;
    logic             sync_r;
    // Registered outputs
    p5g_pkg::p5g_pad_t pad_r;
    logic             in_val_r;
    logic             irq_out_r;
    // Decoded mode
    logic             irq_mode;
    logic             drv_lvl;

    // Pad level is asynchronous, two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    // Reserved codes fall back to plain I/O
    always_comb
    begin
        irq_mode = (cfg.sel == p5g_pkg::SEL_IRQ);
        drv_lvl  = (irq_mode ? irq_src : drive_val) ^ cfg.inv;
    end

    // Driver: open drain only ever pulls low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_r <= '0;
        end
        else if (cfg.dir)
        begin
            pad_r <= '0;
        end
        else if (cfg.od)
        begin
            pad_r.val <= 1'b0;
            pad_r.oe  <= ~drv_lvl;
        end
        else
        begin
            pad_r.val <= drv_lvl;
            pad_r.oe  <= 1'b1;
        end
    end

    // Input path and interrupt forwarding
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_val_r  <= 1'b0;
            irq_out_r <= 1'b0;
        end
        else
        begin
            in_val_r  <= sync_r ^ cfg.inv;
            irq_out_r <= irq_mode & cfg.dir & (sync_r ^ cfg.inv);
        end
    end

    assign pin_out = pad_r.val;
    assign pin_oe  = pad_r.oe;
    assign in_val  = in_val_r;
    assign irq_out = irq_out_r;

endmodule

// ---- verilog/p5g_top.sv ----
`timescale 1ns/1ps
module p5g_top #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and standby power-on reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Board pins
    input  wire logic [p5g_pkg::PIN_CNT-1:0] pin_in,
    output logic [p5g_pkg::PIN_CNT-1:0]      pin_out,
    output logic [p5g_pkg::PIN_CNT-1:0]      pin_oe,
    // Port data path
    input  wire logic [p5g_pkg::PIN_CNT-1:0] gpio_drive,
    output logic [p5g_pkg::PIN_CNT-1:0]      gpio_in,
    // Legacy interrupt lines, indexed by line number
    input  wire logic [p5g_pkg::IRQ_W-1:0]   irq_src,
    output logic [p5g_pkg::IRQ_W-1:0]        irq_line
);

    localparam int unsigned N = p5g_pkg::PIN_CNT;

    // Per-pin configuration
    p5g_pkg::p5g_cfg_t          cfg_q [N];
    // Per-pin write strobes
    logic [N-1:0]               wr_en;
    // Forwarded interrupt per pin
    logic [N-1:0]               irq_pin;
    // Decoded pin of the current address
    logic [2:0]                 hit_pin;
    logic                       hit;
    // Bus phases
    logic                       setup_ph;
    logic                       access_ph;
    // Read data register
    logic [31:0]                prdata_r;
    logic [31:0]                prdata_nxt;
    // Cycles since reset release, saturating, for checks only
    logic [1:0]                 live_cnt_r;

    // Maps a byte address to a pin, NO_PIN on a miss
    function automatic logic [2:0] addr_pin(input logic [ADDR_W-1:0] a);
        logic [2:0] p;
        p = p5g_pkg::NO_PIN;
        for (int i = 0; i < N; i++)
        begin
            if (a == ADDR_W'({p5g_pkg::PIN_REG_IDX[i], 2'b00}))
            begin
                p = 3'(i);
            end
        end
        return p;
    endfunction

    // Phase decode
    always_comb
    begin
        setup_ph  = psel & ~penable;
        access_ph = psel & penable;
        hit_pin   = addr_pin(paddr);
        hit       = (hit_pin != p5g_pkg::NO_PIN);
    end

    // Zero wait states: the access phase always ends at once
    assign pready  = access_ph;
    // Only the six pin registers exist; anything else errors
    assign pslverr = access_ph & ~hit;

    // Read data is captured in setup so it comes from a flop
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (setup_ph && !pwrite)
        begin
            prdata_nxt = '0;
            if (hit)
            begin
                prdata_nxt = {24'h0000_00, cfg_q[hit_pin]};
            end
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
        end
        else
        begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // Helper counter for checks after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            live_cnt_r <= '0;
        end
        else if (live_cnt_r != 2'h3)
        begin
            live_cnt_r <= live_cnt_r + 2'h1;
        end
    end

    // One register and one pad cell per pin
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_pin
            // Write lands only at the completing access edge, low lane
            assign wr_en[g] = access_ph & pwrite & pstrb[0] & (hit_pin == 3'(g));

            // Configuration register
            p5g_cfg_reg u_reg (
                .pclk    (pclk),
                .presetn (presetn),
                .wr_en   (wr_en[g]),
                .wdata   (pwdata[7:0]),
                .cfg     (cfg_q[g])
            );

            // Pad logic, interrupt source picked by line number
            p5g_pin_cell u_cell (
                .pclk      (pclk),
                .presetn   (presetn),
                .cfg       (cfg_q[g]),
                .pin_in    (pin_in[g]),
                .pin_out   (pin_out[g]),
                .pin_oe    (pin_oe[g]),
                .drive_val (gpio_drive[g]),
                .irq_src   (irq_src[p5g_pkg::PIN_IRQ_NUM[g]]),
                .in_val    (gpio_in[g]),
                .irq_out   (irq_pin[g])
            );

            // Input direction never drives the pad
            dir_input_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                cfg_q[g].dir |=> !pin_oe[g])
            else $error("pin driven while configured as input");

            // Polarity relation over sync and output flops
            polarity_path_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (live_cnt_r == 2'h3) && $stable(cfg_q[g].inv)
                |-> gpio_in[g] == ($past(pin_in[g], 3) ^ cfg_q[g].inv))
            else $error("input value does not follow pin and polarity");

            // Non-interrupt codes keep the line quiet
            irq_quiet_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (cfg_q[g].sel != p5g_pkg::SEL_IRQ) |=> !irq_line[p5g_pkg::PIN_IRQ_NUM[g]])
            else $error("interrupt line active outside interrupt select");

            // Open drain never drives a high level
            open_drain_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (cfg_q[g].od && !cfg_q[g].dir) |=> (!pin_out[g]))
            else $error("open-drain output drove high");

            // Push-pull output always drives
            push_pull_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (!cfg_q[g].od && !cfg_q[g].dir) |=> pin_oe[g] && (pin_out[g] ==
                    ($past(cfg_q[g].sel == p5g_pkg::SEL_IRQ) ?
                     $past(irq_src[p5g_pkg::PIN_IRQ_NUM[g]]) : $past(gpio_drive[g])) ^ $past(cfg_q[g].inv)))
            else $error("push-pull output level wrong");

            // Write to the pin index updates the register next cycle
            write_hit_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                access_ph && pwrite && pstrb[0] && (paddr == ADDR_W'({p5g_pkg::PIN_REG_IDX[g], 2'b00}))
                |=> cfg_q[g] == ($past(pwdata[7:0]) & p5g_pkg::CFG_WMASK))
            else $error("pin register not written at its index");

            // Reserved field stays clear
            rsv_zero_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                cfg_q[g].rsv == 3'h0)
            else $error("reserved bits hold a one");

            // Reset value seen right after release
            reset_value_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (live_cnt_r == 2'h0) |-> cfg_q[g] == p5g_pkg::CFG_RESET)
            else $error("pin register not at reset value after reset");

            // Writes elsewhere leave this register alone, catches decode aliasing
            write_miss_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                !(access_ph && pwrite && pstrb[0] && (paddr == ADDR_W'({p5g_pkg::PIN_REG_IDX[g], 2'b00})))
                |=> $stable(cfg_q[g]))
            else $error("pin register changed without a write to its index");

            // Input direction never drives a level either
            input_low_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                cfg_q[g].dir |=> !pin_out[g])
            else $error("pin output level set while configured as input");

            // Open drain releases on a high level and pulls on a low one
            drain_enable_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                (cfg_q[g].od && !cfg_q[g].dir) |=> pin_oe[g] != (($past(cfg_q[g].sel == p5g_pkg::SEL_IRQ) ?
                    $past(irq_src[p5g_pkg::PIN_IRQ_NUM[g]]) : $past(gpio_drive[g])) ^ $past(cfg_q[g].inv)))
            else $error("open-drain enable does not follow the level");

            // Output direction never forwards onto the interrupt line
            irq_output_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                !cfg_q[g].dir |=> !irq_line[p5g_pkg::PIN_IRQ_NUM[g]])
            else $error("interrupt line active on an output pin");
        end
    endgenerate

    // Place each pin's interrupt onto its fixed legacy line
    always_comb
    begin
        irq_line = '0;
        for (int i = 0; i < N; i++)
        begin
            irq_line[p5g_pkg::PIN_IRQ_NUM[i]] = irq_pin[i];
        end
    end

    // Pin 4 input forwarded onto line 9
    irq_forward_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_cnt_r == 2'h3) && cfg_q[4].dir && (cfg_q[4].sel == p5g_pkg::SEL_IRQ)
        && $stable(cfg_q[4])
        |-> irq_line[p5g_pkg::PORT5_PIN4_IRQ] == ($past(pin_in[4], 3) ^ cfg_q[4].inv))
    else $error("interrupt line does not follow its pin");

    // Pin 0 input forwarded onto line 3
    pin0_forward_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_cnt_r == 2'h3) && cfg_q[0].dir && (cfg_q[0].sel == p5g_pkg::SEL_IRQ)
        && $stable(cfg_q[0])
        |-> irq_line[p5g_pkg::PORT5_PIN0_IRQ] == ($past(pin_in[0], 3) ^ cfg_q[0].inv))
    else $error("line 3 does not follow pin 0");

    // Pin 5 input forwarded onto line 10
    pin5_forward_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_cnt_r == 2'h3) && cfg_q[5].dir && (cfg_q[5].sel == p5g_pkg::SEL_IRQ)
        && $stable(cfg_q[5])
        |-> irq_line[p5g_pkg::PORT5_PIN5_IRQ] == ($past(pin_in[5], 3) ^ cfg_q[5].inv))
    else $error("line 10 does not follow pin 5");

    // Unmapped access answers with an error, mapped one without
    // Judged from the raw address range, not from the decode function
    slave_error_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        access_ph |-> pready && (pslverr == !((paddr[1:0] == 2'b00)
            && (paddr[ADDR_W-1:2] >= (ADDR_W-2)'(p5g_pkg::PORT5_PIN0_CONFIG_IDX))
            && (paddr[ADDR_W-1:2] <= (ADDR_W-2)'(p5g_pkg::PORT5_PIN5_CONFIG_IDX)))))
    else $error("bus error response wrong");

    // Error response only inside a completing access
    error_gate_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && psel && penable)
    else $error("error response outside an access");

    // Read data never carries reserved or unused bits
    read_reserved_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (prdata[31:8] == 24'h0000_00) && (prdata[6:4] == 3'h0))
    else $error("read data holds a reserved bit");

    // Read data in access phase shows the addressed register
    read_back_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(setup_ph) && access_ph && !pwrite && hit
        |-> prdata == {24'h0000_00, cfg_q[hit_pin]})
    else $error("read data does not match register");

    // Lines with no pin behind them stay low
    unused_line_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_line & 16'hF947) == 16'h0000)
    else $error("unmapped interrupt line active");

endmodule

// ---- tb/p5g_board_model.sv ----
`timescale 1ns/1ps
module p5g_board_model (
    // Design pad side
    input  wire logic [p5g_pkg::PIN_CNT-1:0] pin_out,
    input  wire logic [p5g_pkg::PIN_CNT-1:0] pin_oe,
    // Level the board applies where nobody drives
    input  wire logic [p5g_pkg::PIN_CNT-1:0] ext_lvl,
    // Resolved pad levels
    output logic [p5g_pkg::PIN_CNT-1:0]      pin_in
);
    // Driven pads follow the design, released pads take the board level
    // An open-drain pin that is off is released, so the board level wins there
    always_comb
    begin
        for (int i = 0; i < p5g_pkg::PIN_CNT; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
endmodule

// ---- tb/port5_pin_config_irq_mux_tb.sv ----
`timescale 1ns/1ps
module port5_pin_config_irq_mux_tb;
    // Register index and interrupt line of each pin
    localparam logic [7:0] REG_IDX [6] = '{8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
    localparam int         IRQ_NUM [6] = '{3, 4, 5, 7, 9, 10};
    // Config codes swept: outputs first, then inputs
    localparam logic [7:0] CODES [15] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h04, 8'h0C, 8'h08, 8'h8A,
                                          8'h01, 8'h03, 8'h09, 8'h0B, 8'h05, 8'h0D, 8'h89};
    logic        pclk;
    logic        presetn;
    logic        psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, err;
    logic [5:0]  pin_in, pin_out, pin_oe, gpio_drive, gpio_in, ext_lvl;
    logic [15:0] irq_src, irq_line, eirq;
    logic [7:0]  c;
    logic [5:0]  eo, eout, egin;
    logic        v, pad;
    int          mismatches, n_checks, cycles;

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    p5g_top #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .gpio_drive(gpio_drive), .gpio_in(gpio_in), .irq_src(irq_src), .irq_line(irq_line));

    p5g_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

    // Verdict and end of run
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never completes
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb      = 4'hF;
        gpio_drive = 6'h00;
        irq_src    = 16'h0000;
        ext_lvl    = 6'h2D;
        presetn    = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset contents and pins released
        chk(32'(pin_oe), 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, REG_IDX[i], 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            chk(32'(err), 32'h0000_0000);
        end
        // Unmapped neighbours answer with an error
        apb(1'b1, 8'h45, 32'h0000_00FF);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 8'h3E, 32'h0000_0000);
        chk({rd[31:1], err}, 32'h0000_0001);
        // Distinct values per register, reserved bits dropped
        for (int i = 0; i < 6; i++)
            apb(1'b1, REG_IDX[i], 32'h0000_0070 | 32'(i));
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, REG_IDX[i], 32'h0000_0000);
            chk(rd, 32'(i));
        end
        // Low byte lane off: write must not land
        pstrb <= 4'hE;
        apb(1'b1, REG_IDX[1], 32'h0000_008F);
        pstrb <= 4'hF;
        apb(1'b0, REG_IDX[1], 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        // Sweep every mode on all pins with changing data
        for (int k = 0; k < 15; k++)
        begin
            c = CODES[k];
            gpio_drive <= 6'(8'h15 + k * 5);
            ext_lvl    <= 6'(8'h2D ^ k * 3);
            irq_src    <= 16'h0428 ^ 16'(k * 16'h0111);
            for (int i = 0; i < 6; i++)
                apb(1'b1, REG_IDX[i], {24'h00_0000, c});
            apb(1'b0, REG_IDX[k % 6], 32'h0000_0000);
            chk(rd, 32'(c & 8'h8F));
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            eirq = 16'h0000;
            for (int i = 0; i < 6; i++)
            begin
                v = ((c[3:2] == 2'b10) ? irq_src[IRQ_NUM[i]] : gpio_drive[i]) ^ c[1];
                eo[i]   = c[0] ? 1'b0 : (c[7] ? ~v : 1'b1);
                eout[i] = (c[0] || c[7]) ? 1'b0 : v;
                pad     = eo[i] ? eout[i] : ext_lvl[i];
                egin[i] = pad ^ c[1];
                eirq[IRQ_NUM[i]] = (c[3:2] == 2'b10) & c[0] & (ext_lvl[i] ^ c[1]);
            end
            chk(32'(pin_oe), 32'(eo));
            chk(32'(pin_out), 32'(eout));
            chk(32'(gpio_in), 32'(egin));
            chk(32'(irq_line), 32'(eirq));
        end
        // Second reset in mid-run restores the default
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_IDX[5], 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        summarize();
    end
endmodule
